// file: logic/nvp_arb_if.sv
/*
 * Carrier between the controller state and its arbiter.
 * Assumes one clock domain; all signals are combinational here.
 */
`timescale 1ns/10ps
`default_nettype none
interface nvp_arb_if #(parameter int N = 35);
    import nvp_pkg::*;
    logic [N-1:0]        cand;
    logic [N-1:0]        act;
    logic [PRIO_W-1:0]   prio [N];
    logic [SPLIT_W-1:0]  split;
    logic [ID_W-1:0]     best_id;
    logic [PRIO_W-1:0]   best_prio;
    logic                found;
    logic [GRP_W-1:0]    run_grp;
    modport arb (input cand, act, prio, split, output best_id, best_prio, found, run_grp);
    modport ctl (output cand, act, prio, split, input best_id, best_prio, found, run_grp);
endinterface // nvp_arb_if
`default_nettype wire

// file: logic/nvp_arbiter.sv
/*
 * Picks the most urgent candidate and the running group of active lines.
 * Assumes candidates are already masked by enable and active state.
 */
`timescale 1ns/10ps
`default_nettype none
module nvp_arbiter
    import nvp_pkg::*;
(
    nvp_arb_if.arb a
);
    // ========================================================================
    // Lowest level wins, lowest number breaks ties; sub part orders equal groups.
    always_comb begin
        a.found     = 1'b0;
        a.best_id   = '0;
        a.best_prio = '1;
        a.run_grp   = GRP_IDLE;
        for (int i = 0; i < $bits(a.cand); i++) begin
            if (a.cand[i] && (!a.found || a.prio[i] < a.best_prio)) begin
                a.found     = 1'b1;
                a.best_id   = ID_W'(i);
                a.best_prio = a.prio[i];
            end
            if (a.act[i] && nvp_group(a.prio[i], a.split) < a.run_grp) begin
                a.run_grp = nvp_group(a.prio[i], a.split);
            end
        end
    end
endmodule // nvp_arbiter
`default_nettype wire

// file: logic/nvp_ctrl.sv
/*
 * Nested vectored interrupt controller: per-line pending and active state,
 * priority and sensing registers, request to the core.
 * Assumes a synchronous register port and core entry and exit strobes.
 */
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - 35 lines, each with priority 0 to 7
// - Smaller level is more urgent
// - Priority splits into group and subpriority
// - Priority changes take effect immediately
// - NMI input and tail-chaining supported
// - Core saves and restores context itself
// - Pulses sampled on rising clock edge
// - Level input high while not active pends
// - Rising edge on pulse input pends
// - Set-pending or trigger write pends
// - Handler entry: pending becomes active
// - Level exit: pend if still asserted
// - Pulse during handler: active and pending
// - No pulse during handler: inactive after
// - Level clear ignored while input high
// - Pulse clear drops only pending
// - Registers decoded in two address ranges
module nvp_ctrl
    import nvp_pkg::*;
#(
    parameter int N = NUM_IRQ
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic [N-1:0]     irq_i,
    input  wire logic             nmi_i,
    input  wire logic [31:0]      addr_i,
    input  wire logic [31:0]      wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [31:0]      rdata_o,
    input  wire logic             entry_i,
    input  wire logic [ID_W-1:0]  entry_id_i,
    input  wire logic             exit_i,
    input  wire logic [ID_W-1:0]  exit_id_i,
    output logic                  irq_req_o,
    output logic      [ID_W-1:0]  irq_id_o,
    output logic                  nmi_req_o
);
    logic [N-1:0]        en_reg;
    logic [N-1:0]        pend_reg;
    logic [N-1:0]        act_reg;
    logic [N-1:0]        pulse_reg;
    logic [PRIO_W-1:0]   prio_reg [N];
    logic [SPLIT_W-1:0]  split_reg;
    logic                nmi_pend_reg;
    logic                nmi_act_reg;
    logic [31:0]         rdata_reg;
    logic                irq_req_reg;
    logic [ID_W-1:0]     irq_id_reg;
    logic [N:0]          rise;
    logic                bank;
    logic                in_range;
    logic [5:0]          pidx;
    logic [N-1:0]        wmask;
    logic [N-1:0]        ent_vec;
    logic [N-1:0]        ext_vec;
    logic [N-1:0]        trig_vec;
    logic [N-1:0]        sw_set;
    logic [N-1:0]        sw_clr;
    logic [N-1:0]        hw_set;
    logic [N-1:0]        pend_clr;
    logic [N-1:0]        pend_next;
    logic [N-1:0]        act_next;

    nvp_arb_if #(.N(N)) arb ();

    // ========================================================================
    // Helpers
    function automatic logic [31:0] bank_word(input logic [N-1:0] v, input logic b);
        logic [63:0] w;
        w = 64'(v);
        return b ? w[63:32] : w[31:0];
    endfunction

    function automatic logic hit(input logic [31:0] base);
        return addr_i[31:BANK_BIT+1] == base[31:BANK_BIT+1];
    endfunction

    function automatic logic [N-1:0] id_vec(input logic [ID_W-1:0] id);
        return N'(64'h1 << id);
    endfunction

    // ========================================================================
    // Line sampling; the NMI rides as the top bit.
    nvp_edge_sampler #(.W(N + 1)) u_sampler (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .line_i  ({nmi_i, irq_i}),
        .rise_o  (rise)
    );

    // ========================================================================
    // Register decode
    assign bank     = addr_i[BANK_BIT];
    assign in_range = (addr_i >= RANGE0_LO && addr_i <= RANGE0_HI) ||
                      (addr_i >= RANGE1_LO && addr_i <= RANGE1_HI);
    assign pidx     = 6'((addr_i - A_PRIO) >> BANK_BIT);
    assign wmask    = N'(bank ? {wdata_i, 32'h0} : {32'h0, wdata_i});

    // ========================================================================
    // Pending and active next state
    always_comb begin
        ent_vec  = entry_i ? id_vec(entry_id_i) : '0;
        ext_vec  = exit_i ? id_vec(exit_id_i) : '0;
        trig_vec = (wr_i && in_range && hit(A_TRIG)) ? id_vec(wdata_i[ID_W-1:0]) : '0;
        sw_set   = ((wr_i && in_range && hit(A_SET_PEND)) ? wmask : '0) | trig_vec;
        sw_clr   = (wr_i && in_range && hit(A_CLR_PEND)) ? wmask : '0;
        // Level lines pend while idle or on exit if still high; pulses on edges.
        hw_set   = (~pulse_reg & irq_i & ((~act_reg & ~ent_vec) | ext_vec))
                 | (pulse_reg & rise[N-1:0]);
        // A held level line ignores a software clear.
        pend_clr = ent_vec | (sw_clr & ~(~pulse_reg & irq_i))
                 | (ext_vec & ~pulse_reg);
        pend_next = (pend_reg & ~pend_clr) | hw_set | sw_set;
        act_next  = (act_reg & ~ext_vec) | ent_vec;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pend_reg <= '0;
            act_reg  <= '0;
        end else begin
            pend_reg <= pend_next;
            act_reg  <= act_next;
        end
    end

    // ========================================================================
    // Software control registers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            en_reg    <= '0;
            pulse_reg <= '0;
            split_reg <= SPLIT_RST;
        end else if (wr_i && in_range) begin
            if (hit(A_SET_EN)) begin
                en_reg <= en_reg | wmask;
            end
            if (hit(A_CLR_EN)) begin
                en_reg <= en_reg & ~wmask;
            end
            if (hit(A_SENSE)) begin
                pulse_reg <= bank ? {wmask[N-1:32], pulse_reg[31:0]}
                                  : {pulse_reg[N-1:32], wmask[31:0]};
            end
            if (addr_i[31:BANK_BIT] == A_SPLIT[31:BANK_BIT]) begin
                split_reg <= wdata_i[SPLIT_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < N; i++) begin
                prio_reg[i] <= PRIO_RST;
            end
        end else if (wr_i && addr_i >= A_PRIO && addr_i <= A_PRIO_END + 32'h3) begin
            for (int i = 0; i < N; i++) begin
                if (pidx == 6'(i / LANES)) begin
                    prio_reg[i] <= wdata_i[LANE_W*(i%LANES)+PRIO_LSB +: PRIO_W];
                end
            end
        end
    end

    // ========================================================================
    // Read port: data stand in the cycle after the strobe only.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= '0;
        end else if (!rd_i || !in_range) begin
            rdata_reg <= '0;
        end else if (hit(A_SET_EN) || hit(A_CLR_EN)) begin
            rdata_reg <= bank_word(en_reg, bank);
        end else if (hit(A_SET_PEND) || hit(A_CLR_PEND)) begin
            rdata_reg <= bank_word(pend_reg, bank);
        end else if (hit(A_ACTIVE)) begin
            rdata_reg <= bank_word(act_reg, bank);
        end else if (hit(A_SENSE)) begin
            rdata_reg <= bank_word(pulse_reg, bank);
        end else if (addr_i[31:BANK_BIT] == A_SPLIT[31:BANK_BIT]) begin
            rdata_reg <= 32'(split_reg);
        end else if (addr_i >= A_PRIO && addr_i <= A_PRIO_END + 32'h3) begin
            rdata_reg <= '0;
            for (int i = 0; i < N; i++) begin
                if (pidx == 6'(i / LANES)) begin
                    rdata_reg[LANE_W*(i%LANES)+PRIO_LSB +: PRIO_W] <= prio_reg[i];
                end
            end
        end else begin
            rdata_reg <= '0;
        end
    end

    // ========================================================================
    // Arbitration and requests
    assign arb.cand  = pend_reg & en_reg & ~act_reg;
    assign arb.act   = act_reg;
    assign arb.prio  = prio_reg;
    assign arb.split = split_reg;

    nvp_arbiter u_arbiter (
        .a (arb)
    );

    // Only a strictly more urgent group preempts; after an exit the next
    // pending line is offered at once, so the core can chain handlers.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            irq_req_reg <= 1'b0;
            irq_id_reg  <= '0;
        end else begin
            irq_req_reg <= arb.found && !nmi_act_reg &&
                           nvp_group(arb.best_prio, split_reg) < arb.run_grp;
            irq_id_reg  <= arb.best_id;
        end
    end

    // The core stacks and unstacks its own state around entry and exit.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            nmi_pend_reg <= 1'b0;
            nmi_act_reg  <= 1'b0;
        end else begin
            nmi_pend_reg <= rise[N] || (nmi_pend_reg && !(entry_i && entry_id_i == NMI_ID));
            nmi_act_reg  <= (entry_i && entry_id_i == NMI_ID) ||
                            (nmi_act_reg && !(exit_i && exit_id_i == NMI_ID));
        end
    end

    assign rdata_o   = rdata_reg;
    assign irq_req_o = irq_req_reg;
    assign irq_id_o  = irq_id_reg;
    assign nmi_req_o = nmi_pend_reg;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_level_pends: assert property (
        1'b1 |=> (($past(~pulse_reg & irq_i & ~act_reg & ~ent_vec) & ~pend_reg) == '0))
        else $error("level input high while idle did not pend");
    a_pulse_latch: assert property (
        1'b1 |=> (($past(pulse_reg & rise[N-1:0]) & ~pend_reg) == '0))
        else $error("pulse edge not latched");
    a_sw_set_pends: assert property (
        1'b1 |=> (($past(sw_set) & ~pend_reg) == '0))
        else $error("software set did not pend");
    a_entry_activates: assert property (
        entry_i && entry_id_i < ID_W'(N) && !(exit_i && exit_id_i == entry_id_i)
        |=> act_reg[$past(entry_id_i)])
        else $error("entry did not make line active");
    a_exit_clears_act: assert property (
        exit_i && exit_id_i < ID_W'(N) && !(entry_i && entry_id_i == exit_id_i)
        |=> !act_reg[$past(exit_id_i)])
        else $error("exit left line active");
    a_level_exit_samp: assert property (
        exit_i && exit_id_i < ID_W'(N) && !pulse_reg[exit_id_i] && !sw_set[exit_id_i]
        && !(entry_i && entry_id_i == exit_id_i)
        |=> pend_reg[$past(exit_id_i)] == $past(irq_i[exit_id_i]))
        else $error("level exit did not resample input");
    a_level_clr_hold: assert property (
        sw_clr != '0 |=> (($past(sw_clr & ~pulse_reg & irq_i & pend_reg & ~ent_vec)
                          & ~pend_reg) == '0))
        else $error("clear of held level line changed state");
    a_pulse_clr: assert property (
        sw_clr != '0 |=> (($past(sw_clr & pulse_reg & ~rise[N-1:0] & ~sw_set)
                          & pend_reg) == '0))
        else $error("pulse clear left line pending");
    a_req_order: assert property (
        arb.found && !nmi_act_reg && nvp_group(arb.best_prio, split_reg) < arb.run_grp
        |=> irq_req_reg && irq_id_reg == $past(arb.best_id))
        else $error("urgent candidate not requested");
    a_nmi_latch: assert property (
        rise[N] |=> nmi_req_o)
        else $error("nmi edge not latched");
    a_nmi_blocks_req: assert property (
        nmi_act_reg |=> !irq_req_o)
        else $error("normal request offered while nmi handler runs");

    c_tail_chain: cover property (exit_i ##1 irq_req_o);
    c_nested:     cover property (entry_i && act_reg != '0);
    c_act_pend:   cover property ((act_reg & pend_reg) != '0);
    c_nmi_entry:  cover property (nmi_req_o ##1 entry_i && entry_id_i == NMI_ID);
endmodule // nvp_ctrl
`default_nettype wire

// file: logic/nvp_edge_sampler.sv
/*
 * Samples interrupt lines on the clock and flags rising transitions.
 * Assumes the lines are synchronous to the clock.
 */
`timescale 1ns/10ps
`default_nettype none
module nvp_edge_sampler #(
    parameter int W = 36
) (
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] line_i,
    output logic      [W-1:0] rise_o
);
    logic [W-1:0] prev_reg;

    // ========================================================================
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= line_i;
        end
    end

    assign rise_o = line_i & ~prev_reg;
endmodule // nvp_edge_sampler
`default_nettype wire

// file: logic/nvp_pkg.sv
/*
 * Shared constants of the nested interrupt controller: sizes, register
 * addresses, reset values and the priority grouping function.
 * Assumes byte addresses on the private peripheral bus, one word per register.
 */
`default_nettype none
package nvp_pkg;
    // ========================================================================
    // Sizes
    localparam int NUM_IRQ = 35;
    localparam int PRIO_W  = 3;
    localparam int ID_W    = 6;
    localparam int GRP_W   = 4;
    localparam int SPLIT_W = 2;
    localparam logic [ID_W-1:0]    NMI_ID    = 6'h23;
    localparam logic [GRP_W-1:0]   GRP_IDLE  = 4'h8;
    localparam logic [SPLIT_W-1:0] SPLIT_RST = 2'h0;
    localparam logic [PRIO_W-1:0]  PRIO_RST  = 3'h0;
    localparam int PRIO_LSB  = 5;
    localparam int LANE_W    = 8;
    localparam int LANES     = 4;
    // ========================================================================
    // Decoded address ranges and register addresses
    localparam logic [31:0] RANGE0_LO  = 32'he000e100;
    localparam logic [31:0] RANGE0_HI  = 32'he000e4ef;
    localparam logic [31:0] RANGE1_LO  = 32'he000ef00;
    localparam logic [31:0] RANGE1_HI  = 32'he000ef03;
    localparam logic [31:0] A_SET_EN   = 32'he000e100;
    localparam logic [31:0] A_CLR_EN   = 32'he000e180;
    localparam logic [31:0] A_SET_PEND = 32'he000e200;
    localparam logic [31:0] A_CLR_PEND = 32'he000e280;
    localparam logic [31:0] A_ACTIVE   = 32'he000e300;
    localparam logic [31:0] A_PRIO     = 32'he000e400;
    localparam logic [31:0] A_PRIO_END = 32'he000e420;
    localparam logic [31:0] A_SPLIT    = 32'he000e4e0;
    localparam logic [31:0] A_SENSE    = 32'he000e4e8;
    localparam logic [31:0] A_TRIG     = 32'he000ef00;
    localparam int BANK_BIT = 2;

    // Preemption compares only the group part; split counts subpriority bits.
    function automatic logic [GRP_W-1:0] nvp_group(input logic [PRIO_W-1:0]  p,
                                                   input logic [SPLIT_W-1:0] s);
        return GRP_W'(p >> s);
    endfunction
endpackage
`default_nettype wire

// file: verif/nvp_core_model.sv
/*
 * Core side model: takes requests, enters handlers, returns on command.
 * Assumes the controller's registered request outputs and one clock.
 */
`timescale 1ns/10ps
`default_nettype none
module nvp_core_model
    import nvp_pkg::*;
(
    input  wire logic            clock_i,
    input  wire logic            reset_i,
    input  wire logic            irq_req_i,
    input  wire logic [ID_W-1:0] irq_id_i,
    input  wire logic            nmi_req_i,
    input  wire logic            accept_i,
    input  wire logic            ret_i,
    input  wire logic [3:0]      lag_i,
    output logic                 entry_o,
    output logic      [ID_W-1:0] entry_id_o,
    output logic                 exit_o,
    output logic      [ID_W-1:0] exit_id_o,
    output logic      [3:0]      depth_o
);
    // ========================================
    // Handler stack
    logic [ID_W-1:0] stack_reg [8];
    logic [1:0]      hold_reg;
    logic [3:0]      wait_reg;
    // The hold spans the edges a registered request needs to drop.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            entry_o    <= 1'b0;
            exit_o     <= 1'b0;
            entry_id_o <= 6'h00;
            exit_id_o  <= 6'h00;
            depth_o    <= 4'h0;
            hold_reg   <= 2'h0;
            wait_reg   <= 4'h0;
        end else begin
            entry_o    <= 1'b0;
            exit_o     <= 1'b0;
            entry_id_o <= ~entry_id_o;
            exit_id_o  <= ~exit_id_o;
            if (hold_reg != 2'h0) begin
                hold_reg <= hold_reg - 2'h1;
            end
            if (ret_i && depth_o != 4'h0) begin
                exit_o    <= 1'b1;
                exit_id_o <= stack_reg[depth_o[2:0] - 3'h1];
                depth_o   <= depth_o - 4'h1;
                hold_reg  <= 2'h2;
            end else if (accept_i && hold_reg == 2'h0 && (irq_req_i || nmi_req_i)) begin
                if (wait_reg < lag_i) begin
                    wait_reg <= wait_reg + 4'h1;
                end else begin
                    wait_reg   <= 4'h0;
                    entry_o    <= 1'b1;
                    entry_id_o <= nmi_req_i ? NMI_ID : irq_id_i;
                    stack_reg[depth_o[2:0]] <= nmi_req_i ? NMI_ID : irq_id_i;
                    depth_o    <= depth_o + 4'h1;
                    hold_reg   <= 2'h3;
                end
            end
        end
    end
endmodule // nvp_core_model
`default_nettype wire

// file: verif/tb_top.sv
/*
 * Self-checking bench of the interrupt controller with a core model.
 * Assumes the register map and latencies of the controller package.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import nvp_pkg::*;
;
    logic            clock = 1'b0;
    logic            reset, nmi, wr, rd, acc, ret, ent, ext, req, nmi_req;
    logic [34:0]     irq;
    logic [31:0]     addr, wdata, rdata;
    logic [3:0]      lag, depth;
    logic [ID_W-1:0] ent_id, ext_id, req_id;
    int              n_mismatch, tests_run;
    nvp_ctrl dut_u (.clock_i(clock), .reset_i(reset), .irq_i(irq), .nmi_i(nmi),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .entry_i(ent), .entry_id_i(ent_id), .exit_i(ext), .exit_id_i(ext_id),
        .irq_req_o(req), .irq_id_o(req_id), .nmi_req_o(nmi_req));
    nvp_core_model core_u (.clock_i(clock), .reset_i(reset), .irq_req_i(req),
        .irq_id_i(req_id), .nmi_req_i(nmi_req), .accept_i(acc), .ret_i(ret),
        .lag_i(lag), .entry_o(ent), .entry_id_o(ent_id), .exit_o(ext),
        .exit_id_o(ext_id), .depth_o(depth));
    always #20 clock = ~clock;
    // ========================================
    // Bus and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic setp(input int i, input int p);
        wr_reg(A_PRIO + 32'(4 * (i / 4)), 32'(p) << (8 * (i % 4) + PRIO_LSB));
    endtask
    // Waits a bounded time, since a new request takes two edges to show.
    task automatic chk_req(input logic r, input logic [ID_W-1:0] id);
        logic [ID_W:0] want;
        want = {r, id};
        step(2);
        for (int i = 0; i < 12 && {req, req_id & {ID_W{r}}} !== want; i++) step(1);
        chk(32'({req, req_id & {ID_W{r}}}), 32'(want));
    endtask
    task automatic ret_h();
        @(posedge clock);
        ret <= 1'b1;
        @(posedge clock);
        ret <= 1'b0;
        step(4);
    endtask
    task automatic take();
        acc <= 1'b1;
        step(8);
        acc <= 1'b0;
    endtask
    // ========================================
    // Scenarios
    task automatic s_regs();
        chk(32'(req), 32'h0);
        wr_reg(A_SET_EN, 32'hffffffff);
        wr_reg(A_SET_EN + 32'h4, 32'hffffffff);
        rd_reg(A_SET_EN, 32'hffffffff);
        rd_reg(A_SET_EN + 32'h4, 32'h7);
        wr_reg(A_CLR_EN, 32'hffffffff);
        wr_reg(A_CLR_EN + 32'h4, 32'h7);
        wr_reg(A_PRIO + 32'h4, 32'hffffffff);
        rd_reg(A_PRIO + 32'h4, 32'he0e0e0e0);
        wr_reg(A_PRIO + 32'h4, 32'h0);
        wr_reg(32'he001e100, 32'h1);
        rd_reg(A_SET_EN, 32'h0);
        wr_reg(32'he000e4f0, 32'hffffffff);
        rd_reg(32'he000e4f0, 32'h0);
        rd_reg(32'he000ef04, 32'h0);
    endtask
    task automatic s_pulse();
        wr_reg(A_SENSE, 32'h8);
        setp(3, 2);
        rd_reg(A_PRIO, 32'h40000000);
        wr_reg(A_SET_EN, 32'h8);
        @(posedge clock);
        irq[3] <= 1'b1;
        @(posedge clock);
        irq[3] <= 1'b0;
        rd_reg(A_SET_PEND, 32'h8);
        chk_req(1'b1, 6'd3);
        lag = 4'h3;
        acc = 1'b1;
        step(8);
        rd_reg(A_ACTIVE, 32'h8);
        rd_reg(A_SET_PEND, 32'h0);
        @(posedge clock);
        irq[3] <= 1'b1;
        @(posedge clock);
        irq[3] <= 1'b0;
        rd_reg(A_SET_PEND, 32'h8);
        rd_reg(A_ACTIVE, 32'h8);
        ret_h();
        step(8);
        rd_reg(A_ACTIVE, 32'h8);
        rd_reg(A_SET_PEND, 32'h0);
        ret_h();
        rd_reg(A_ACTIVE, 32'h0);
        rd_reg(A_SET_PEND, 32'h0);
        acc = 1'b0;
        lag = 4'h0;
    endtask
    task automatic s_level();
        wr_reg(A_SENSE, 32'h0);
        setp(5, 1);
        wr_reg(A_SET_EN, 32'h20);
        irq[5] <= 1'b1;
        rd_reg(A_SET_PEND, 32'h20);
        wr_reg(A_CLR_PEND, 32'h20);
        rd_reg(A_SET_PEND, 32'h20);
        chk_req(1'b1, 6'd5);
        take();
        rd_reg(A_ACTIVE, 32'h20);
        ret_h();
        rd_reg(A_SET_PEND, 32'h20);
        rd_reg(A_ACTIVE, 32'h0);
        take();
        irq[5] <= 1'b0;
        ret_h();
        rd_reg(A_SET_PEND, 32'h0);
        rd_reg(A_ACTIVE, 32'h0);
        wr_reg(A_SET_PEND, 32'h20);
        rd_reg(A_SET_PEND, 32'h20);
        wr_reg(A_CLR_PEND, 32'h20);
        rd_reg(A_SET_PEND, 32'h0);
        wr_reg(A_CLR_EN, 32'h20);
    endtask
    task automatic s_prio();
        setp(8, 1);
        setp(12, 6);
        wr_reg(A_SET_EN, 32'h1100);
        wr_reg(A_SET_PEND, 32'h1100);
        chk_req(1'b1, 6'd8);
        setp(8, 7);
        chk_req(1'b1, 6'd12);
        take();
        chk_req(1'b0, 6'd0);
        setp(8, 5);
        chk_req(1'b1, 6'd8);
        wr_reg(A_SPLIT, 32'h2);
        chk_req(1'b0, 6'd0);
        wr_reg(A_SPLIT, 32'h0);
        ret_h();
        wr_reg(A_CLR_PEND, 32'h1100);
        wr_reg(A_CLR_EN, 32'h1100);
    endtask
    task automatic s_trig();
        wr_reg(A_SENSE, 32'h100000);
        wr_reg(A_TRIG, 32'd20);
        rd_reg(A_SET_PEND, 32'h100000);
        wr_reg(A_TRIG, 32'd35);
        wr_reg(A_TRIG, 32'd34);
        rd_reg(A_SET_PEND + 32'h4, 32'h4);
        wr_reg(A_CLR_PEND + 32'h4, 32'h4);
        wr_reg(A_CLR_PEND, 32'h100000);
        rd_reg(A_SET_PEND, 32'h0);
        wr_reg(A_SET_EN, 32'h100000);
        wr_reg(A_TRIG, 32'd20);
        take();
        wr_reg(A_TRIG, 32'd20);
        wr_reg(A_CLR_PEND, 32'h100000);
        rd_reg(A_SET_PEND, 32'h0);
        rd_reg(A_ACTIVE, 32'h100000);
        ret_h();
        rd_reg(A_ACTIVE, 32'h0);
        wr_reg(A_CLR_EN, 32'h100000);
    endtask
    task automatic s_nmi();
        @(posedge clock);
        nmi <= 1'b1;
        @(posedge clock);
        nmi <= 1'b0;
        step(2);
        chk(32'(nmi_req), 32'h1);
        take();
        chk(32'(nmi_req), 32'h0);
        wr_reg(A_SET_EN, 32'h1);
        wr_reg(A_SET_PEND, 32'h1);
        chk_req(1'b0, 6'd0);
        ret_h();
        chk_req(1'b1, 6'd0);
        wr_reg(A_CLR_PEND, 32'h1);
        wr_reg(A_CLR_EN, 32'h1);
        chk(32'(depth), 32'h0);
    endtask
    // ========================================
    // Run control
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        {reset, nmi, wr, rd, acc, ret} = 6'h20;
        {irq, addr, wdata, lag} = '0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        s_regs();
        s_pulse();
        s_level();
        s_prio();
        s_trig();
        s_nmi();
        test_done();
    end
    initial begin
        #400000;
        n_mismatch++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
